// [logic/pgo_pkg.sv]
// shared constants, register map and types for the pixel gain/offset path
// assumes one 10 MHz clock and an AXI4-Lite slave port with 32-bit data
//
// Overview of operation
// - gain below 2731 is clamped up to 2731 for every output width
// - gain above 16383, 8192 or 6144 (8, 10, 12 bit output) is clamped down
// - gain resets to 4096, which is unity gain, zero decibels
// - pixel gain equals setting over 4096; decibels are 20 log10 of that ratio
// - gain is written as decibels or as raw integer; both read back consistent
// - offset resets to zero, adding nothing to pixels
// - 8-bit output: offset -255..+255, sixteen steps move output one count
// - 10-bit output: offset -1023..+1023, four steps move output one count
// - 12-bit output: offset -4095..+4095, each step moves output one count
// - offset is written in output counts or as raw integer in separate fields
// - single line 40 MHz unbinned: line valid delay 9.68 us, edge 10.03 us
// - dual line 80 MHz unbinned: line valid delay 12.73 us, edge 13.08 us
// - single line 80 MHz: 12.71 us unbinned, 15.01 us binned, fixed per mode
package pgo_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned PIX_W         = 12;
   localparam int unsigned GAIN_W        = 14;
   localparam int unsigned OFF_W         = 13;
   localparam int unsigned UNITY_SHIFT   = 12;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_GAIN_RAW = 8'h04;
   localparam logic [7:0] ADDR_GAIN_DB  = 8'h08;
   localparam logic [7:0] ADDR_OFF_RAW  = 8'h0C;
   localparam logic [7:0] ADDR_OFF_DN   = 8'h10;
   localparam logic [7:0] ADDR_STATUS   = 8'h14;
   localparam logic [7:0] ADDR_LVD      = 8'h18;

   // control register fields
   localparam int unsigned CTRL_WIDTH_LSB = 0;
   localparam int unsigned CTRL_DUAL_BIT  = 2;
   localparam int unsigned CTRL_F80_BIT   = 3;
   localparam int unsigned CTRL_BIN_BIT   = 4;
   localparam int unsigned CTRL_EXP_LSB   = 5;
   localparam logic [6:0]  CTRL_RESET     = 7'h00;

   localparam logic [1:0] WIDTH_8  = 2'h0;
   localparam logic [1:0] WIDTH_10 = 2'h1;
   localparam logic [1:0] EXP_EDGE = 2'h1;

   localparam logic [31:0] RESP_OKAY   = 32'h0000_0000;
   localparam logic [1:0]  RESP_DECERR = 2'h3;

   // gain limits and reset value
   localparam logic [13:0] GAIN_MIN    = 14'h0AAB;
   localparam logic [13:0] GAIN_MAX_8  = 14'h3FFF;
   localparam logic [13:0] GAIN_MAX_10 = 14'h2000;
   localparam logic [13:0] GAIN_MAX_12 = 14'h1800;
   localparam logic [13:0] GAIN_RESET  = 14'h1000;

   // offset limits and steps-per-count shifts
   localparam logic [12:0] OFF_LIM_8   = 13'h00FF;
   localparam logic [12:0] OFF_LIM_10  = 13'h03FF;
   localparam logic [12:0] OFF_LIM_12  = 13'h0FFF;
   localparam logic [12:0] OFF_RESET   = 13'h0000;
   localparam logic [2:0]  OFF_SHIFT_8  = 3'h4;
   localparam logic [2:0]  OFF_SHIFT_10 = 3'h2;
   localparam logic [2:0]  OFF_SHIFT_12 = 3'h0;

   // decibel field: signed half-dB code, table index = code + DB_CODE_BIAS
   localparam int unsigned DB_STEPS     = 32;
   localparam logic [7:0]  DB_CODE_BIAS = 8'h07;
   localparam logic [13:0] DB_TABLE [DB_STEPS] = '{
      14'h0AB2, 14'h0B54, 14'h0C00, 14'h0CB6, 14'h0D76, 14'h0E43, 14'h0F1B, 14'h1000,
      14'h10F3, 14'h11F4, 14'h1304, 14'h1425, 14'h1556, 14'h169A, 14'h17F1, 14'h195C,
      14'h1ADC, 14'h1C74, 14'h1E23, 14'h1FED, 14'h21D1, 14'h23D2, 14'h25F1, 14'h2831,
      14'h2A92, 14'h2D18, 14'h2FC4, 14'h3299, 14'h3598, 14'h38C5, 14'h3C22, 14'h3FB2};

   // least line valid delays in ns, index {80 MHz, dual line, binning, edge exposure}
   localparam int unsigned LVD_MIN_NS [16] = '{
      9680, 10030, 13580, 13930, 9730, 10080, 13630, 13980,
      12710, 13060, 15010, 15360, 12730, 13080, 15030, 15380};

   function automatic logic [7:0] lvd_cycles(input int unsigned idx);
      int unsigned c;
      c = (LVD_MIN_NS[idx] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return c[7:0];
   endfunction : lvd_cycles

   typedef struct packed {
      logic              last;
      logic [PIX_W-1:0]  data;
   } pgo_pix_s;

   typedef enum logic [1:0] {
      LV_IDLE = 2'b00,
      LV_WAIT = 2'b01,
      LV_LINE = 2'b10
   } pgo_lv_e;
endpackage : pgo_pkg

// [logic/pgo_top.sv]
// pixel gain/offset stage with line valid timing and an AXI4-Lite register port
// assumes pixel inputs and the line trigger are synchronous to aclk
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module pgo_fifo #(
   parameter int unsigned W     = 13,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   // fill side
   input  wire logic                     in_valid,
   output wire logic                     in_ready,
   input  wire logic [W-1:0]             in_data,
   // drain side
   output wire logic                     out_valid,
   input  wire logic                     out_ready,
   output wire logic [W-1:0]             out_data,
   // fill level
   output wire logic [$clog2(DEPTH):0]   level
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_r;
   logic [AW:0]  rd_r;
   wire  logic   push = in_valid && in_ready;
   wire  logic   pop  = out_valid && out_ready;

   assign level     = wr_r - rd_r;
   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (wr_r != rd_r);
   assign out_data  = mem[rd_r[AW-1:0]];

   always_ff @(posedge aclk) begin
      if (push) mem[wr_r[AW-1:0]] <= in_data;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop) rd_r <= rd_r + 1'b1;
      end
   end
endmodule : pgo_fifo

module pgo_top #(
   parameter int unsigned FIFO_DEPTH = 16
) (
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite write address and data
   input  wire logic                s_axi_awvalid,
   output wire logic                s_axi_awready,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_wvalid,
   output wire logic                s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   // axi4-lite write response
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output logic [1:0]               s_axi_bresp,
   // axi4-lite read
   input  wire logic                s_axi_arvalid,
   output wire logic                s_axi_arready,
   input  wire logic [7:0]          s_axi_araddr,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   // sensor pixel stream
   input  wire logic                s_valid,
   output wire logic                s_ready,
   input  wire pgo_pkg::pgo_pix_s   s_pix,
   input  wire logic                line_start,
   // video out
   output logic                     m_valid,
   input  wire logic                m_ready,
   output pgo_pkg::pgo_pix_s        m_pix,
   output logic                     lval
);
   import pgo_pkg::*;

   localparam int unsigned LW = $clog2(FIFO_DEPTH) + 1;

   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
      $error("pgo_top: FIFO_DEPTH must be a power of two of at least 2");
   end

   // ---------------- registers ----------------
   logic [6:0]   ctrl_r;
   logic [13:0]  gain_r;
   logic [12:0]  off_r;

   wire logic [1:0] width_code = ctrl_r[CTRL_WIDTH_LSB +: 2];
   wire logic [3:0] lvd_idx    = {ctrl_r[CTRL_F80_BIT], ctrl_r[CTRL_DUAL_BIT],
                                  ctrl_r[CTRL_BIN_BIT],
                                  ctrl_r[CTRL_EXP_LSB +: 2] == EXP_EDGE};

   // width dependent limits
   wire logic [13:0] gain_max = (width_code == WIDTH_8)  ? GAIN_MAX_8 :
                                (width_code == WIDTH_10) ? GAIN_MAX_10 : GAIN_MAX_12;
   wire logic [12:0] off_lim  = (width_code == WIDTH_8)  ? OFF_LIM_8 :
                                (width_code == WIDTH_10) ? OFF_LIM_10 : OFF_LIM_12;
   wire logic [2:0]  off_sh   = (width_code == WIDTH_8)  ? OFF_SHIFT_8 :
                                (width_code == WIDTH_10) ? OFF_SHIFT_10 : OFF_SHIFT_12;
   wire logic [3:0]  out_sh   = {1'b0, off_sh};
   wire logic [11:0] pix_max  = 12'hFFF >> out_sh;

   // effective settings are re-clamped whenever the output width changes
   wire logic [13:0] gain_eff = (gain_r < GAIN_MIN) ? GAIN_MIN :
                                (gain_r > gain_max) ? gain_max : gain_r;
   wire logic signed [12:0] off_s   = off_r;
   wire logic signed [12:0] lim_s   = off_lim;
   wire logic signed [12:0] off_eff = (off_s > lim_s)  ? lim_s :
                                      (off_s < -lim_s) ? -lim_s : off_s;
   wire logic signed [12:0] off_cnt = off_eff >>> off_sh;
   wire logic [7:0] lvd_cyc = lvd_cycles(32'(lvd_idx));

   // decibel readback: highest table step not above the effective gain, or step 0 when every step is above it
   logic [DB_STEPS-1:0] db_le;
   for (genvar i = 0; i < DB_STEPS; i++) begin : g_db
      assign db_le[i] = (DB_TABLE[i] <= gain_eff);
   end
   logic [5:0] db_cnt;
   always_comb begin
      db_cnt = '0;
      for (int i = 0; i < DB_STEPS; i++) db_cnt = db_cnt + {5'h00, db_le[i]};
   end
   wire logic [7:0] db_idx  = (db_cnt == 6'h00) ? 8'h00 : {2'b00, db_cnt - 6'h01};
   wire logic [7:0] db_code = db_idx - DB_CODE_BIAS;

   // ---------------- axi4-lite slave ----------------
   logic        aw_held_r;
   logic        w_held_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;

   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire logic do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   wire logic do_read  = s_axi_arvalid && s_axi_arready;

   // byte-lane merge of write data over the current ctrl, raw gain or raw offset value, else over zero
   logic [31:0] wr_old;
   logic [31:0] wr_val;
   always_comb begin
      unique case (aw_addr_r)
         ADDR_CTRL:     wr_old = {25'h0, ctrl_r};
         ADDR_GAIN_RAW: wr_old = {18'h0, gain_r};
         ADDR_OFF_RAW:  wr_old = {{19{off_r[12]}}, off_r};
         default:       wr_old = RESP_OKAY;
      endcase
   end
   for (genvar b = 0; b < 4; b++) begin : g_strb
      assign wr_val[8*b +: 8] = w_strb_r[b] ? w_data_r[8*b +: 8] : wr_old[8*b +: 8];
   end

   wire logic wr_hit = (aw_addr_r == ADDR_CTRL) || (aw_addr_r == ADDR_GAIN_RAW) ||
                       (aw_addr_r == ADDR_GAIN_DB) || (aw_addr_r == ADDR_OFF_RAW) ||
                       (aw_addr_r == ADDR_OFF_DN) || (aw_addr_r == ADDR_STATUS) ||
                       (aw_addr_r == ADDR_LVD);

   // decibel write: code plus bias, limited to the table
   wire logic signed [8:0] db_wr  = $signed({wr_val[7], wr_val[7:0]}) + 9'sd7;
   wire logic [4:0]        db_sel = db_wr[8] ? 5'h00 : (db_wr > 9'sd31) ? 5'h1F : db_wr[4:0];

   // count write: limited to the range then scaled to raw steps
   wire logic signed [12:0] dn_wr  = wr_val[12:0];
   wire logic signed [12:0] dn_lim = lim_s >>> off_sh;
   wire logic signed [12:0] dn_cl  = (dn_wr > dn_lim) ? dn_lim :
                                     (dn_wr < -dn_lim) ? -dn_lim : dn_wr;
   wire logic [12:0]        dn_raw = dn_cl <<< off_sh;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RESET;
         gain_r <= GAIN_RESET;
         off_r  <= OFF_RESET;
      end else if (do_write) begin
         unique case (aw_addr_r)
            ADDR_CTRL:     ctrl_r <= wr_val[6:0];
            ADDR_GAIN_RAW: gain_r <= wr_val[13:0];
            ADDR_GAIN_DB:  gain_r <= DB_TABLE[db_sel];
            ADDR_OFF_RAW:  off_r  <= wr_val[12:0];
            ADDR_OFF_DN:   off_r  <= dn_raw;
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r    <= 1'b0;
         w_held_r     <= 1'b0;
         aw_addr_r    <= '0;
         w_data_r     <= '0;
         w_strb_r     <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? 2'b00 : RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read mux
   logic        rd_hit;
   logic [31:0] rd_val;
   pgo_lv_e     lv_st_r;
   logic [LW-1:0] fifo_level;
   logic          fifo_in_ready;
   logic          fifo_out_valid;
   wire logic [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
   always_comb begin
      rd_hit = 1'b1;
      unique case (rd_addr)
         ADDR_CTRL:     rd_val = {25'h0, ctrl_r};
         ADDR_GAIN_RAW: rd_val = {18'h0, gain_eff};
         ADDR_GAIN_DB:  rd_val = {{24{db_code[7]}}, db_code};
         ADDR_OFF_RAW:  rd_val = {{19{off_eff[12]}}, off_eff};
         ADDR_OFF_DN:   rd_val = {{19{off_cnt[12]}}, off_cnt};
         ADDR_STATUS:   rd_val = {16'h0, 8'(fifo_level), 3'b000, lval, lv_st_r,
                                  !fifo_in_ready, !fifo_out_valid};
         ADDR_LVD:      rd_val = {24'h0, lvd_cyc};
         default: begin
            rd_hit = 1'b0;
            rd_val = RESP_OKAY;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= '0;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_hit ? 2'b00 : RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- pixel datapath ----------------
   logic        p1_valid_r;
   logic        p1_last_r;
   logic [25:0] p1_prod_r;

   assign s_ready = !p1_valid_r || fifo_in_ready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p1_valid_r <= 1'b0;
         p1_last_r  <= 1'b0;
         p1_prod_r  <= '0;
      end else if (s_ready) begin
         p1_valid_r <= s_valid;
         p1_last_r  <= s_pix.last;
         p1_prod_r  <= s_pix.data * gain_eff;
      end
   end

   // scale by 1/4096 and to the output width, add offset counts, saturate
   wire logic [25:0]        scaled  = p1_prod_r >> (UNITY_SHIFT + 32'(out_sh));
   wire logic signed [16:0] sum     = $signed({2'b00, scaled[14:0]}) + 17'(off_cnt);
   wire logic [11:0]        clamped = sum[16] ? 12'h000 :
                                      (sum > $signed({5'h00, pix_max})) ? pix_max :
                                      sum[11:0];
   pgo_pix_s fifo_in;
   pgo_pix_s fifo_out;
   assign fifo_in = '{last: p1_last_r, data: clamped};

   wire logic pop = (lv_st_r == LV_LINE) && fifo_out_valid && (!m_valid || m_ready);

   pgo_fifo #(
      .W     ($bits(pgo_pix_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (p1_valid_r),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in),
      .out_valid (fifo_out_valid),
      .out_ready (pop),
      .out_data  (fifo_out),
      .level     (fifo_level)
   );

   // ---------------- line valid timing ----------------
   logic [7:0] lv_cnt_r;
   logic       last_popped_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lv_st_r       <= LV_IDLE;
         lv_cnt_r      <= '0;
         lval          <= 1'b0;
         last_popped_r <= 1'b0;
         m_valid       <= 1'b0;
         m_pix         <= '0;
      end else begin
         if (pop) begin
            m_valid <= 1'b1;
            m_pix   <= fifo_out;
         end else if (m_ready) begin
            m_valid <= 1'b0;
         end
         unique case (lv_st_r)
            LV_IDLE: if (line_start) begin
               lv_st_r  <= LV_WAIT;
               lv_cnt_r <= lvd_cyc - 8'h01;
            end
            LV_WAIT: if (lv_cnt_r == 8'h00) begin
               lv_st_r <= LV_LINE;
               lval    <= 1'b1;
            end else begin
               lv_cnt_r <= lv_cnt_r - 8'h01;
            end
            LV_LINE: begin
               if (pop && fifo_out.last) begin
                  lv_st_r       <= LV_IDLE;
                  last_popped_r <= 1'b1;
               end
            end
            default: lv_st_r <= LV_IDLE;
         endcase
         // line valid falls once the last pixel has left the output register
         if (last_popped_r && m_valid && m_ready) begin
            lval          <= 1'b0;
            last_popped_r <= 1'b0;
         end
      end
   end
endmodule : pgo_top

// [bench/pgo_top_properties.sv]
// port-level assertions for the gain/offset stage
// assumes one clock aclk and synchronous active-low aresetn
`timescale 1ns/1ps
module pgo_properties (
   // clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // register port
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [31:0]       s_axi_rdata,
   // video out
   input wire logic              m_valid,
   input wire logic              m_ready,
   input wire pgo_pkg::pgo_pix_s m_pix,
   input wire logic              lval
);
   import pgo_pkg::*;
   logic [7:0] lo_cnt_r;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles that line valid has been low
   always_ff @(posedge aclk) begin
      if (!aresetn || lval) lo_cnt_r <= 8'h00;
      else if (lo_cnt_r != 8'hFF) lo_cnt_r <= lo_cnt_r + 8'h01;
   end
   property p_pix_hold;
      m_valid && !m_ready |=> m_valid && $stable(m_pix);
   endproperty
   a_pix_hold: assert property (p_pix_hold) else $error("pixel changed while stalled");
   property p_lval_end;
      m_valid && m_ready && m_pix.last |-> ##[1:2] !lval;
   endproperty
   a_lval_end: assert property (p_lval_end) else $error("line valid stuck after last");
   property p_lval_min;
      $rose(lval) |-> lo_cnt_r >= 8'h60;
   endproperty
   a_lval_min: assert property (p_lval_min) else $error("line valid delay too short");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write answer late");
   property p_w_lock;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_lock: assert property (p_w_lock) else $error("write taken during response");
   property p_r_lock;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_r_lock: assert property (p_r_lock) else $error("read taken during answer");
endmodule : pgo_properties

bind pgo_top pgo_properties u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .m_valid(m_valid), .m_ready(m_ready), .m_pix(m_pix),
   .lval(lval));

// [bench/pgo_grabber.sv]
// frame grabber model: accepts video beats with random stalls
// assumes video out is synchronous to aclk
`timescale 1ns/1ps
module pgo_grabber #(
   parameter logic [31:0] SEED = 32'h0000_1D2B
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // video in
   input wire logic m_valid,
   output logic     m_ready
);
   logic [31:0] st_r;
   wire  [31:0] st_a   = st_r ^ (st_r << 13);
   wire  [31:0] st_b   = st_a ^ (st_a >> 17);
   wire  [31:0] st_nxt = st_b ^ (st_b << 5);
   // stalls about one beat in four
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r    <= SEED;
         m_ready <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         m_ready <= st_nxt[1:0] != 2'h0;
      end
   end
endmodule : pgo_grabber

// [bench/pixel_gain_offset_path_tb.sv]
// self-checking bench for the gain/offset stage
// assumes pgo_pkg, pgo_top, pgo_properties and pgo_grabber are compiled first
`timescale 1ns/1ps
module pixel_gain_offset_path_tb;
   import pgo_pkg::*;
   logic        aclk, aresetn, awv, wv, bready, arv, rready, s_valid, line_start;
   wire logic   awr, wr_rdy, bv, arr, rv, s_ready, m_valid, m_ready, lval;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, seed, rd;
   wire  [31:0] rdata;
   wire  [1:0]  bresp, rresp;
   logic [1:0]  rsp;
   pgo_pix_s    s_pix;
   wire pgo_pix_s m_pix;
   logic [11:0] exp_q[$];
   int          n_mismatch, check_count, cyc, i;
   logic [31:0] modes [7] = '{32'h0000_0000, 32'h0000_0020, 32'h0000_0040, 32'h0000_000C,
                              32'h0000_002C, 32'h0000_0008, 32'h0000_0018};
   int          ns [7]    = '{9680, 10030, 9680, 12730, 13080, 12710, 15010};

   pgo_top #(.FIFO_DEPTH(16)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awaddr), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(araddr), .s_axi_rvalid(rv), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_valid(s_valid), .s_ready(s_ready), .s_pix(s_pix),
      .line_start(line_start), .m_valid(m_valid), .m_ready(m_ready), .m_pix(m_pix),
      .lval(lval));
   pgo_grabber u_grab (.aclk(aclk), .aresetn(aresetn), .m_valid(m_valid), .m_ready(m_ready));

   always #50 aclk = ~aclk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic int clampi(input int v, input int lo, input int hi);
      return v < lo ? lo : (v > hi ? hi : v);
   endfunction : clampi
   function automatic int gmax(input int w);
      return w == 0 ? 16383 : (w == 1 ? 8192 : 6144);
   endfunction : gmax
   function automatic int lim(input int w);
      return (4096 >> (4 - 2 * w)) - 1;
   endfunction : lim
   function automatic int exp_pix(input int px, input int g, input int o, input int w);
      int s;
      int v;
      s = 4 - 2 * w;
      v = ((px * clampi(g, 2731, gmax(w))) >>> 12) >>> s;
      v = v + (clampi(o, -lim(w), lim(w)) >>> s);
      return clampi(v, 0, lim(w));
   endfunction : exp_pix

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_go, w_go, b_go;
      @(posedge aclk);
      awv    <= 1'b1;
      wv     <= 1'b1;
      bready <= 1'b1;
      awaddr <= a;
      wdata  <= d;
      do begin
         @(negedge aclk);
         aw_go = awv && awr;
         w_go  = wv && wr_rdy;
         b_go  = bv && bready;
         @(posedge aclk);
         if (aw_go) awv <= 1'b0;
         if (w_go) wv <= 1'b0;
         if (b_go) bready <= 1'b0;
      end while (!b_go);
      check(bresp, 0);
   endtask : wr
   task automatic rd_reg(input logic [7:0] a);
      logic ar_go, r_go;
      @(posedge aclk);
      arv    <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_go = arv && arr;
         r_go  = rv && rready;
         rd    = rdata;
         rsp   = rresp;
         @(posedge aclk);
         if (ar_go) arv <= 1'b0;
         if (r_go) rready <= 1'b0;
      end while (!r_go);
   endtask : rd_reg
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rd_reg(a);
      check({30'h0, rsp}, 32'h0000_0000);
      check(rd & m, e & m);
   endtask : rchk

   task automatic run_line(input logic [31:0] ctrl, input int t, input int g, input int o);
      int n;
      int w;
      logic [31:0] r;
      w = int'(ctrl[1:0]);
      wr(ADDR_CTRL, ctrl);
      wr(ADDR_GAIN_RAW, g);
      wr(ADDR_OFF_RAW, o);
      rchk(ADDR_GAIN_RAW, clampi(g, 2731, gmax(w)), 32'h0000_3FFF);
      rchk(ADDR_OFF_RAW, clampi(o, -lim(w), lim(w)), 32'h0000_1FFF);
      rchk(ADDR_LVD, (t + 99) / 100, 32'h0000_00FF);
      for (n = 0; n < 17; n++) begin
         r = rnd();
         @(posedge aclk);
         s_valid <= 1'b1;
         s_pix   <= {n == 16, r[11:0]};
         exp_q.push_back(12'(exp_pix(int'(r[11:0]), g, o, w)));
         do @(negedge aclk); while (!s_ready);
      end
      @(posedge aclk);
      s_pix <= {1'b0, 12'h000};
      @(negedge aclk);
      check({31'h0, s_ready}, 32'h0000_0000);
      rchk(ADDR_STATUS, 32'h0000_1002, 32'h0000_FFFF);
      @(posedge aclk);
      s_valid    <= 1'b0;
      line_start <= 1'b1;
      @(posedge aclk);
      line_start <= 1'b0;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (!lval && n < 300);
      check(n - 1, (t + 99) / 100);
      n = 0;
      while ((exp_q.size() != 0 || lval) && n < 500) begin
         @(negedge aclk);
         n++;
      end
      check(exp_q.size(), 0);
   endtask : run_line

   // beats are judged at the negedge before the accepting edge
   always @(negedge aclk) begin
      if (m_valid && m_ready && exp_q.size() != 0) begin
         check({m_pix.last, m_pix.data}, {exp_q.size() == 1, exp_q[0]});
         void'(exp_q.pop_front());
      end
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         test_done();
      end
   end

   initial begin
      {aclk, aresetn, awv, wv, bready, arv, rready, s_valid, line_start} = '0;
      {awaddr, araddr, wdata, s_pix} = '0;
      seed = 32'h0000_D295;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(ADDR_GAIN_RAW, 4096, 32'h0000_3FFF);
      rchk(ADDR_OFF_RAW, 0, 32'h0000_1FFF);
      rchk(ADDR_GAIN_DB, 0, 32'h0000_00FF);
      rd_reg(8'h1C);
      check({30'h0, rsp}, 32'h0000_0003);
      wr(ADDR_GAIN_DB, 12);
      rchk(ADDR_GAIN_RAW, int'(4096.0 * 10.0 ** (12 / 40.0)), 32'h0000_3FFF);
      rchk(ADDR_GAIN_DB, 12, 32'h0000_00FF);
      for (i = 0; i < 3; i++) begin
         wr(ADDR_CTRL, i);
         wr(ADDR_OFF_DN, 32'hFFFF_FFFF);
         rchk(ADDR_OFF_RAW, -(1 << (4 - 2 * i)), 32'h0000_1FFF);
         wr(ADDR_OFF_RAW, -4095);
         rchk(ADDR_OFF_RAW, -lim(i), 32'h0000_1FFF);
      end
      for (i = 0; i < 7; i++) begin
         rd = rnd();
         run_line(modes[i] | (i % 3), ns[i], int'(rd[13:0]), $signed(rd[28:16]));
      end
      run_line(32'h0000_0001, 9680, 16383, 4095);
      run_line(32'h0000_0002, 9680, 0, -4095);
      test_done();
   end
endmodule : pixel_gain_offset_path_tb
